// File: shared/sct_cfg.svh
// timing constants and widths for the async static ram cycle controller
// assumes a 200 MHz mclk; counts derived from ns figures, rounded as noted
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH
`define SCT_CLK_PS       5000
`define SCT_ADDR_W       21
`define SCT_DATA_W       8
`define SCT_T_CYCLE_PS   45000
`define SCT_T_ACCESS_PS  45000
`define SCT_T_OE_DATA_PS 22000
`define SCT_T_SEL_END_PS 35000
`define SCT_T_SETUP_PS   25000
`define SCT_T_TURNOFF_PS 18000
// all times round up to whole clock cycles
`define SCT_CYC_UP(t)    (((t) + `SCT_CLK_PS - 1) / `SCT_CLK_PS)
`define SCT_CNT_W        5
`define SCT_CNT_ZERO     5'h00
`define SCT_CNT_ONE      5'h01
`endif

// File: shared/sct_pkg.sv
// types for the async static ram cycle controller
// assumes sct_cfg.svh is on the include path
`include "sct_cfg.svh"
package sct_pkg;
  typedef struct packed {
    logic                    write;
    logic [`SCT_ADDR_W-1:0]  addr;
    logic [`SCT_DATA_W-1:0]  wdata;
  } sct_req_t;

  typedef struct packed {
    logic                    select_active_low;
    logic                    select_active_high;
    logic                    write_strobe_n;
    logic                    output_enable_n;
    logic [`SCT_ADDR_W-1:0]  addr;
  } sct_pins_t;

  typedef enum logic [2:0] {
    SCT_IDLE   = 3'h0,
    SCT_RD     = 3'h1,
    SCT_RD_END = 3'h3,
    SCT_WR_TO  = 3'h2,
    SCT_WR     = 3'h6,
    SCT_WR_END = 3'h7,
    SCT_GAP    = 3'h5
  } sct_state_t;
endpackage

// File: hw/sct_timer.sv
// down counter used to time the read, turnoff and write phases of a ram cycle
// assumes load and load_val come from the controller state machine
`timescale 1ns/1ps
`include "sct_cfg.svh"
module sct_timer #(
  parameter int W = `SCT_CNT_W
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = load_val;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // done when the loaded count has run down to one remaining edge
  // kept free of load: the caller loads on done, which would close a loop
  assign done = (cnt <= W'(1));
endmodule

// File: hw/sct_ctrl.sv
// host-side controller driving an asynchronous byte-wide static ram
// assumes data lines resolved outside; one request at a time, held until ack
//
// Contract
// - write keeps device selected at least 35 ns before write end
// - write address stable at least 35 ns before write end
// - address may change only at or after write end
// - address valid no later than write start
// - write data driven at least 25 ns before terminating edge
// - write data held valid until the terminating edge
// - write happens only while strobe low and both selects active
// - setup and hold timed against the edge that ends the write
// - strobe pulse at least turnoff delay plus data setup with oe low
// - deselect may coincide with start of retention
// - selected only when active-low select low and active-high high
// - never drive data lines while the device drives read data
`timescale 1ns/1ps
`include "sct_cfg.svh"
module sct_ctrl
  import sct_pkg::*;
#(
  parameter int ADDR_W = `SCT_ADDR_W,
  parameter int DATA_W = `SCT_DATA_W
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire sct_req_t          req,
  input  wire logic              retain,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output sct_pins_t              pins,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe
);
  localparam logic [`SCT_CNT_W-1:0] RD_CYC =
    `SCT_CNT_W'(`SCT_CYC_UP(`SCT_T_ACCESS_PS) + 1);
  localparam logic [`SCT_CNT_W-1:0] TO_CYC =
    `SCT_CNT_W'(`SCT_CYC_UP(`SCT_T_TURNOFF_PS));
  localparam logic [`SCT_CNT_W-1:0] WR_CYC =
    `SCT_CNT_W'(`SCT_CYC_UP(`SCT_T_SEL_END_PS));
  localparam logic [`SCT_CNT_W-1:0] CYC_MIN =
    `SCT_CNT_W'(`SCT_CYC_UP(`SCT_T_CYCLE_PS));

  sct_state_t              state;
  sct_state_t              next_state;
  sct_pins_t               next_pins;
  logic [DATA_W-1:0]       next_dq_out;
  logic                    next_dq_oe;
  logic                    next_rsp_valid;
  logic [DATA_W-1:0]       next_rsp_rdata;
  logic [`SCT_CNT_W-1:0]   cyc;
  logic [`SCT_CNT_W-1:0]   next_cyc;
  logic                    t_load;
  logic [`SCT_CNT_W-1:0]   t_val;
  logic                    t_done;

  sct_timer #(.W(`SCT_CNT_W)) u_timer (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .load     (t_load),
    .load_val (t_val),
    .done     (t_done)
  );

  assign req_ready = (state == SCT_IDLE) && !retain;

  always_comb begin
    next_state     = state;
    next_pins      = pins;
    next_dq_out    = dq_out;
    next_dq_oe     = dq_oe;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    next_cyc       = (cyc != `SCT_CNT_ZERO) ? cyc - `SCT_CNT_ONE : cyc;
    t_load         = 1'b0;
    t_val          = RD_CYC;
    unique case (state)
      SCT_IDLE: begin
        // deselected while idle; retention may begin at once
        next_pins.select_active_low  = 1'b1;
        next_pins.select_active_high = 1'b0;
        next_pins.write_strobe_n     = 1'b1;
        next_pins.output_enable_n    = 1'b1;
        next_dq_oe                   = 1'b0;
        if (req_valid && !retain) begin
          // address, selects and output enable change together: zero setup
          next_pins.addr               = req.addr[ADDR_W-1:0];
          next_pins.select_active_low  = 1'b0;
          next_pins.select_active_high = 1'b1;
          next_cyc                     = CYC_MIN;
          t_load                       = 1'b1;
          if (req.write) begin
            next_dq_out = req.wdata[DATA_W-1:0];
            t_val       = TO_CYC;
            next_state  = SCT_WR_TO;
          end else begin
            next_pins.output_enable_n = 1'b0;
            t_val                     = RD_CYC;
            next_state                = SCT_RD;
          end
        end
      end
      SCT_RD: begin
        // host never drives dq during reads
        next_dq_oe = 1'b0;
        if (t_done) begin
          // sample before address moves, not inside the hold window
          next_rsp_rdata = dq_in;
          next_rsp_valid = 1'b1;
          next_state     = SCT_RD_END;
        end
      end
      SCT_RD_END: begin
        next_pins.output_enable_n    = 1'b1;
        next_pins.select_active_low  = 1'b1;
        next_pins.select_active_high = 1'b0;
        next_state                   = SCT_GAP;
      end
      SCT_WR_TO: begin
        // strobe low first; data driven three cycles (15 ns) after it, as the turnoff count starts a cycle early
        next_pins.write_strobe_n = 1'b0;
        if (t_done) begin
          next_dq_oe = 1'b1;
          t_load     = 1'b1;
          t_val      = WR_CYC;
          next_state = SCT_WR;
        end
      end
      SCT_WR: begin
        if (t_done) begin
          // strobe rises first and terminates the write; data stays
          next_pins.write_strobe_n = 1'b1;
          next_state               = SCT_WR_END;
        end
      end
      SCT_WR_END: begin
        // data and selects released one cycle after the terminating edge
        next_dq_oe                   = 1'b0;
        next_pins.select_active_low  = 1'b1;
        next_pins.select_active_high = 1'b0;
        next_rsp_valid               = 1'b1;
        next_state                   = SCT_GAP;
      end
      SCT_GAP: begin
        // stretches short cycles out to the minimum cycle time
        if (cyc <= `SCT_CNT_ONE) begin
          next_state = SCT_IDLE;
        end
      end
      default: begin
        next_state = SCT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= SCT_IDLE;
      pins      <= '{select_active_low: 1'b1, select_active_high: 1'b0,
                     write_strobe_n: 1'b1, output_enable_n: 1'b1, addr: '0};
      dq_out    <= '0;
      dq_oe     <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      cyc       <= `SCT_CNT_ZERO;
    end else begin
      state     <= next_state;
      pins      <= next_pins;
      dq_out    <= next_dq_out;
      dq_oe     <= next_dq_oe;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      cyc       <= next_cyc;
    end
  end
endmodule

// File: verif/sct_ctrl_monitor.sv
// pin timing checks for the ram cycle controller
// assumes it is bound onto sct_ctrl; one clock domain
`timescale 1ns/1ps
`include "sct_cfg.svh"
module sct_ctrl_monitor
  import sct_pkg::*;
#(
  parameter int DATA_W = `SCT_DATA_W
) (
  input wire logic              mclk,
  input wire logic              arst_n,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire sct_req_t          req,
  input wire logic              retain,
  input wire logic              rsp_valid,
  input wire logic [DATA_W-1:0] rsp_rdata,
  input wire sct_pins_t         pins,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe
);
  wire sel = !pins.select_active_low && pins.select_active_high;
  wire ws = pins.write_strobe_n;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_end; $rose(ws); endsequence
  sequence s_fed; dq_oe && $past(dq_oe, 5); endsequence
  a_strobe_sel: assert property (!ws |-> sel)
    else $error("strobe while deselected");
  a_addr_steady: assert property ((!ws ##1 1) |-> $stable(pins.addr))
    else $error("address moved in write");
  a_no_contend: assert property (dq_oe |-> pins.output_enable_n)
    else $error("drive while reading");
  a_data_setup: assert property (s_end |-> s_fed)
    else $error("write data setup short");
  a_data_hold: assert property (s_end |-> dq_oe && $stable(dq_out))
    else $error("write data not held");
  a_sel_wr_end: assert property (s_end |-> sel && $past(sel, 7))
    else $error("select too short");
  a_strobe_width: assert property ($fell(ws) |-> !ws[*8] ##1 !ws)
    else $error("strobe pulse short");
  a_cycle_min: assert property ($rose(sel) |-> sel[*8] ##1 sel)
    else $error("cycle too short");
endmodule
bind sct_ctrl sct_ctrl_monitor #(.DATA_W(DATA_W)) i_mon (.mclk, .arst_n, .req_valid,
  .req_ready, .req, .retain, .rsp_valid, .rsp_rdata, .pins, .dq_in, .dq_out, .dq_oe);

// File: verif/sct_sram_model.sv
// behavioural async byte-wide static ram on the controller pins
// assumes dq_out and dq_oe come straight from the controller
`timescale 1ns/1ps
`include "sct_cfg.svh"
module sct_sram_model
  import sct_pkg::*;
#(
  parameter real T_ACC = 45.0
) (
  input  wire sct_pins_t  pins,
  input  wire logic [7:0] dq_out,
  input  wire logic       dq_oe,
  output logic [7:0]      dq_in
);
  logic [7:0] mem [logic [`SCT_ADDR_W-1:0]];
  logic       wr = 1'b0;
  realtime    t_a = 0.0;
  realtime    t_o = 0.0;
  wire sel = !pins.select_active_low && pins.select_active_high;
  wire rd = sel && !pins.output_enable_n && pins.write_strobe_n;
  always @(pins.addr or sel) t_a = $realtime;
  always @(rd) t_o = $realtime;
  // any control going inactive ends the write; undriven data stores unknown
  always @(pins or sel or dq_out) begin
    if (wr && !(sel && !pins.write_strobe_n)) mem[pins.addr] = dq_oe ? dq_out : 8'hXX;
    wr = sel && !pins.write_strobe_n;
  end
  // released line toggles so a stale sample never passes
  initial dq_in = 8'h00;
  always #1 begin
    if (dq_oe) dq_in = dq_out;
    else if (!rd) dq_in = ~dq_in;
    else if ($realtime - t_a >= 10.0)
      dq_in = ($realtime - t_a >= T_ACC && $realtime - t_o >= 22.0)
        ? (mem.exists(pins.addr) ? mem[pins.addr] : 8'h5A) : ~dq_in;
  end
endmodule

// File: verif/sct_ctrl_test.sv
// random writes and read-backs through the ram model
// assumes the controller, its bound monitor and the ram model
`timescale 1ns/1ps
`include "sct_cfg.svh"
module sct_ctrl_test
  import sct_pkg::*;
;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic        retain = 1'b0;
  sct_req_t    req = '0;
  logic        req_ready, rsp_valid, dq_oe;
  logic [7:0]  rsp_rdata, dq_in, dq_out;
  sct_pins_t   pins;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          seed = 80714;
  logic [8:0]  e;
  logic [8:0]  exp_q [$];
  logic [7:0]  shadow [logic [20:0]];
  logic [20:0] pool [4];
  always #2.5 mclk = ~mclk;
  sct_ctrl i_dut (.mclk, .arst_n, .req_valid, .req_ready, .req, .retain, .rsp_valid,
    .rsp_rdata, .pins, .dq_in, .dq_out, .dq_oe);
  // device a little faster than its limit, so the sample edge is not a race
  sct_sram_model #(.T_ACC(44.0)) i_ram (.pins, .dq_out, .dq_oe, .dq_in);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic send(input logic wr, input logic [20:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{write: wr, addr: a, wdata: d};
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      tally_and_finish();
    end
    exp_q.push_back({wr, wr ? 8'h00 : shadow[a]});
    if (wr) shadow[a] = d;
  endtask
  always @(posedge mclk)
    if (rsp_valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
      if (!e[8]) chk(rsp_rdata, e[7:0]);
      else chk({7'h00, e == 9'h1FF}, 8'h00);
    end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) pool[i] = 21'($random(seed));
    for (int r = 0; r < 4; r++) begin
      if (r == 2) begin
        repeat (30) @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({4'h0, pins.select_active_low, pins.select_active_high,
             pins.write_strobe_n, pins.output_enable_n}, 8'h0B);
        arst_n <= 1'b1;
      end
      for (int i = 0; i < 4; i++) send(1'b1, pool[i], 8'($random(seed)));
      for (int i = 0; i < 4; i++) send(1'b0, pool[2'($random(seed))], 8'h00);
    end
    @(posedge mclk);
    retain <= 1'b1;
    req_valid <= 1'b1;
    repeat (20) begin
      @(posedge mclk);
      chk({7'h00, req_ready}, 8'h00);
    end
    chk({6'h00, pins.select_active_low, pins.select_active_high}, 8'h02);
    retain <= 1'b0;
    req_valid <= 1'b0;
    send(1'b0, pool[0], 8'h00);
    repeat (30) @(posedge mclk);
    chk({7'h00, exp_q.size() == 0}, 8'h01);
    tally_and_finish();
  end
endmodule
